/* verilog/sdfp_pkg.sv */
// Purpose: shared constants and types of the sdram / fast-page dram sequencer
// Assumes: apb register offsets are byte addresses, one 32-bit word each
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
`default_nettype none
package sdfp_pkg;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned REQ_WIDTH  = 58;
  // register byte offsets
  localparam logic [11:0] OFS_CONFIG  = 12'h000;
  localparam logic [11:0] OFS_REQUEST = 12'h004;
  localparam logic [11:0] OFS_WDATA   = 12'h008;
  localparam logic [11:0] OFS_RDATA   = 12'h00C;
  localparam logic [11:0] OFS_STATUS  = 12'h010;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] WDATA_RESET  = 32'h0000_0000;
  // config fields
  localparam int CFG_EN   = 0;
  localparam int CFG_FP   = 1;
  localparam int CFG_PW   = 2;
  localparam int CFG_CL3  = 4;
  localparam int CFG_BURST_CYCLE_TIMING_FIELD = 5;
  localparam int CFG_REFRESH_CYCLE_LENGTH_FIELD = 7;
  // request fields
  localparam int REQ_WR    = 24;
  localparam int REQ_BURST = 25;
  localparam int REQ_DMA   = 26;
  localparam int REQ_REFR  = 27;
  // port widths and active lanes
  localparam logic [1:0] PW_8     = 2'h0;
  localparam logic [1:0] PW_16    = 2'h1;
  localparam logic [3:0] LANES_8  = 4'h8;
  localparam logic [3:0] LANES_16 = 4'hC;
  localparam logic [3:0] LANES_32 = 4'hF;
  // sdram commands
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_INH = 4'hF;
  // spacing counts, in bus clock cycles
  localparam logic [3:0] NOP_SINGLE_CL3 = 4'h2;
  localparam logic [3:0] NOP_BURST_CL3  = 4'h5;
  localparam logic [3:0] NOP_SINGLE_CL2 = 4'h1;
  localparam logic [3:0] NOP_BURST_CL2  = 4'h4;
  localparam logic [3:0] INH_CL3        = 4'h3;
  localparam logic [3:0] INH_CL2        = 4'h2;
  localparam logic [3:0] WR_BURST_DATA  = 4'h3;
  localparam logic [2:0] BURST_LAST     = 3'h3;
  localparam logic [3:0] DMA_GAP_TICKS  = 4'hD;
  // address layout and mode word
  localparam int ROW_LO = 10;
  localparam logic [11:0] ADDR_PRE_ALL = 12'h400;
  localparam logic [11:0] MODE_CL3_BL1 = 12'h030;
  localparam logic [11:0] MODE_CL2_BL1 = 12'h020;
  localparam logic [11:0] MODE_BL4     = 12'h002;

  typedef struct packed {
    logic        refr;
    logic        dma;
    logic        burst;
    logic        wr;
    logic [21:0] addr;
    logic [31:0] data;
  } sdfp_req_s;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_PRE = 11'h002, ST_LMR = 11'h004, ST_ACT = 11'h008,
    ST_T1   = 11'h010, ST_RDWR = 11'h020, ST_WAIT = 11'h040, ST_BST = 11'h080,
    ST_INH  = 11'h100, ST_REF = 11'h200, ST_GAP = 11'h400
  } sdfp_state_e;
endpackage
`default_nettype wire

/* verilog/sdfp_seq.sv */
// Purpose: sdram and fast-page dram sequencer behind an apb register file
// Assumes: bus clock arrives as a pin and is sampled by SYS_CLK_I
// Notes on behaviour
// - byte strobes enable lane 3 for 8-bit, lanes 3..2 for 16-bit, all lanes for 32-bit.
// - fast-page cas lines follow the same lane choice as the byte strobes; refresh drives all four cas lines low.
// - outside refresh and initialisation, sdram precharge and activate are issued only when the previous row does not match.
// - cas latency of two or three sets read capture and command spacing.
// - at latency three a single read has two nops before burst terminate.
// - at latency three a burst read has five nops before burst terminate.
// - at latency three three inhibit cycles follow each burst terminate.
// - a write without activate shows the column address in its second cycle.
// - a transfer flagged as dma is followed by a thirteen cycle idle gap.
// - fast-page refresh length follows the refresh cycle field, 01, 10 or 11.
// - byte strobes double as sdram data mask and change on the bus clock rise.
// - in sdram mode cas changes on the bus clock rise.
// - in fast-page mode cas and ras change on the bus clock fall.
// - the row/column select changes on the bus clock rise.
`default_nettype none
module sdfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  assign in_ready_o  = (count < (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sdfp_seq (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        BCLK_I,
  output logic             MEM_CS_N_O,
  output logic             MEM_RAS_N_O,
  output logic      [3:0]  MEM_CAS_N_O,
  output logic             MEM_WE_N_O,
  output logic      [3:0]  BYTE_LANE_STROBE_N_O,
  output logic      [11:0] MEM_ADDR_O,
  output logic             ROW_COL_ADDR_SELECT_O,
  output logic      [31:0] MEM_DQ_O,
  output logic             MEM_DQ_OE_O,
  input  wire logic [31:0] MEM_DQ_I
);
  logic [31:0] config_reg;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] prdata;
  logic        rd_ph;
  logic        bclk_s1, bclk_s2, bclk_s3;
  logic [31:0] dq_s1, dq_s2;
  logic        fifo_ready, fifo_valid, pop;
  logic [sdfp_pkg::REQ_WIDTH-1:0] fifo_out;
  sdfp_pkg::sdfp_req_s  head, cur;
  sdfp_pkg::sdfp_state_e state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic [2:0]  beat, next_beat;
  logic        row_open, init_done;
  logic [11:0] open_row;
  logic [3:0]  cap_wait;
  logic [2:0]  cap_left;
  logic [3:0]  cmd;
  logic [11:0] ma;
  logic        mux_col, dq_drv, lane_on, ras_fp, cas_fp;

  // apb decode
  wire sel_cfg = PADDR_I == sdfp_pkg::OFS_CONFIG;
  wire sel_req = PADDR_I == sdfp_pkg::OFS_REQUEST;
  wire sel_wd  = PADDR_I == sdfp_pkg::OFS_WDATA;
  wire sel_rd  = PADDR_I == sdfp_pkg::OFS_RDATA;
  wire sel_st  = PADDR_I == sdfp_pkg::OFS_STATUS;
  wire mapped  = sel_cfg | sel_req | sel_wd | sel_rd | sel_st;
  wire acc     = PSEL_I & PENABLE_I;
  wire req_push_v = acc & PWRITE_I & sel_req;
  // full fifo stalls the apb write until a slot frees
  assign PREADY_O  = PWRITE_I ? ~(sel_req & ~fifo_ready) : rd_ph;
  assign PSLVERR_O = acc & PREADY_O & ~mapped;
  assign PRDATA_O  = prdata;
  wire wr_en = acc & PWRITE_I & PREADY_O;

  // configuration fields
  wire       en      = config_reg[sdfp_pkg::CFG_EN];
  wire       fp      = config_reg[sdfp_pkg::CFG_FP];
  wire [1:0] pw      = config_reg[sdfp_pkg::CFG_PW +: 2];
  wire       cl3     = config_reg[sdfp_pkg::CFG_CL3];
  wire [1:0] burst_cycle_timing_field    = config_reg[sdfp_pkg::CFG_BURST_CYCLE_TIMING_FIELD +: 2];
  wire [1:0] refresh_cycle_length_field    = config_reg[sdfp_pkg::CFG_REFRESH_CYCLE_LENGTH_FIELD +: 2];
  wire [3:0] lanes   = (pw == sdfp_pkg::PW_8)  ? sdfp_pkg::LANES_8 :
                       (pw == sdfp_pkg::PW_16) ? sdfp_pkg::LANES_16 : sdfp_pkg::LANES_32;
  wire [3:0] burst_cycle_timing_field_m1 = (burst_cycle_timing_field == 2'h0) ? 4'h0 : {2'h0, burst_cycle_timing_field} - 4'h1;
  wire [3:0] refresh_cycle_length_field_n  = (refresh_cycle_length_field == 2'h0) ? 4'h1 : {2'h0, refresh_cycle_length_field};
  wire [3:0] nops    = cl3 ? (cur.burst ? sdfp_pkg::NOP_BURST_CL3 : sdfp_pkg::NOP_SINGLE_CL3)
                           : (cur.burst ? sdfp_pkg::NOP_BURST_CL2 : sdfp_pkg::NOP_SINGLE_CL2);
  wire [3:0] inhs    = cl3 ? sdfp_pkg::INH_CL3 : sdfp_pkg::INH_CL2;
  wire [11:0] mode   = (cl3 ? sdfp_pkg::MODE_CL3_BL1 : sdfp_pkg::MODE_CL2_BL1) |
                       (cur.burst ? sdfp_pkg::MODE_BL4 : 12'h000);
  wire [2:0] last_beat = cur.burst ? sdfp_pkg::BURST_LAST : 3'h0;
  wire [11:0] cur_row = cur.addr[sdfp_pkg::ROW_LO +: 12];
  wire [11:0] cur_col = {2'h0, cur.addr[sdfp_pkg::ROW_LO-1:0]};
  wire row_hit = row_open && (head.addr[sdfp_pkg::ROW_LO +: 12] == open_row);
  wire [31:0] status = {15'h0, ~fifo_ready, 1'b0, open_row, row_open,
                        state != sdfp_pkg::ST_IDLE, init_done};
  wire [31:0] rd_mux = sel_cfg ? config_reg : sel_wd ? wdata : sel_rd ? rdata :
                       sel_st ? status : 32'h0;
  assign head = sdfp_pkg::sdfp_req_s'(fifo_out);

  // bus clock edges, seen through a two-stage synchroniser
  wire tick_r = bclk_s2 & ~bclk_s3;
  wire tick_f = ~bclk_s2 & bclk_s3;

  sdfp_fifo #(.WIDTH(sdfp_pkg::REQ_WIDTH), .DEPTH(sdfp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i       (SYS_CLK_I),
    .rst_b_i     (RST_B_I),
    .in_valid_i  (req_push_v),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({PWDATA_I[sdfp_pkg::REQ_REFR:sdfp_pkg::REQ_WR], PWDATA_I[21:0], wdata}),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out)
  );

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      config_reg <= sdfp_pkg::CONFIG_RESET;
      wdata      <= sdfp_pkg::WDATA_RESET;
      rd_ph      <= 1'b0;
      prdata     <= 32'h0;
    end else begin
      if (wr_en && sel_cfg) config_reg <= PWDATA_I;
      if (wr_en && sel_wd) wdata <= PWDATA_I;
      rd_ph  <= acc & ~PWRITE_I & ~rd_ph;
      prdata <= (acc & ~PWRITE_I & ~rd_ph) ? rd_mux : prdata;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
      dq_s1 <= 32'h0;
      dq_s2 <= 32'h0;
    end else begin
      {bclk_s1, bclk_s2, bclk_s3} <= {BCLK_I, bclk_s1, bclk_s2};
      dq_s1 <= MEM_DQ_I;
      dq_s2 <= dq_s1;
    end
  end

  // sequencer: one state per bus clock cycle, stepped on each rise
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_beat  = beat;
    pop        = 1'b0;
    cmd        = sdfp_pkg::CMD_NOP;
    ma         = cur_row;
    mux_col    = 1'b0;
    dq_drv     = 1'b0;
    lane_on    = 1'b0;
    ras_fp     = 1'b1;
    cas_fp     = 1'b1;
    case (state)
      sdfp_pkg::ST_IDLE: begin
        cmd = en ? sdfp_pkg::CMD_NOP : sdfp_pkg::CMD_INH;
        if (tick_r && en && !init_done && !fp) begin
          next_state = sdfp_pkg::ST_PRE;
        end else if (tick_r && en && (init_done || fp) && fifo_valid) begin
          pop       = 1'b1;
          next_cnt  = refresh_cycle_length_field_n;
          next_beat = 3'h0;
          if (head.refr) next_state = fp ? sdfp_pkg::ST_REF : sdfp_pkg::ST_PRE;
          else if (fp) next_state = sdfp_pkg::ST_ACT;
          else if (row_hit) next_state = head.wr ? sdfp_pkg::ST_T1 : sdfp_pkg::ST_RDWR;
          else if (row_open) next_state = sdfp_pkg::ST_PRE;
          else next_state = sdfp_pkg::ST_ACT;
        end
      end
      sdfp_pkg::ST_PRE: begin
        cmd = sdfp_pkg::CMD_PRE;
        ma  = sdfp_pkg::ADDR_PRE_ALL;
        if (tick_r) begin
          next_state = !init_done ? sdfp_pkg::ST_LMR :
                       cur.refr ? sdfp_pkg::ST_REF : sdfp_pkg::ST_ACT;
        end
      end
      sdfp_pkg::ST_LMR: begin
        cmd = sdfp_pkg::CMD_LMR;
        ma  = mode;
        if (tick_r) next_state = sdfp_pkg::ST_IDLE;
      end
      sdfp_pkg::ST_ACT: begin
        cmd    = sdfp_pkg::CMD_ACT;
        ras_fp = 1'b0;
        if (tick_r) begin
          next_state = sdfp_pkg::ST_RDWR;
          next_cnt   = burst_cycle_timing_field_m1;
        end
      end
      sdfp_pkg::ST_T1: begin
        if (tick_r) next_state = sdfp_pkg::ST_RDWR;
      end
      sdfp_pkg::ST_RDWR: begin
        cmd     = fp ? {3'h7, ~cur.wr} : (cur.wr ? sdfp_pkg::CMD_WR : sdfp_pkg::CMD_RD);
        ma      = cur_col;
        mux_col = 1'b1;
        dq_drv  = cur.wr;
        lane_on = 1'b1;
        ras_fp  = 1'b0;
        cas_fp  = 1'b0;
        if (tick_r && fp) begin
          next_cnt = (cnt == 4'h0) ? burst_cycle_timing_field_m1 : cnt - 4'h1;
          if (cnt == 4'h0) begin
            next_beat = beat + 3'h1;
            if (beat == last_beat) next_state = cur.dma ? sdfp_pkg::ST_GAP : sdfp_pkg::ST_IDLE;
            next_cnt = (beat == last_beat && cur.dma) ? sdfp_pkg::DMA_GAP_TICKS : burst_cycle_timing_field_m1;
          end
        end else if (tick_r) begin
          next_cnt   = cur.wr ? sdfp_pkg::WR_BURST_DATA : nops;
          next_state = (!cur.wr || cur.burst) ? sdfp_pkg::ST_WAIT :
                       cur.dma ? sdfp_pkg::ST_GAP : sdfp_pkg::ST_IDLE;
          if (cur.wr && !cur.burst) next_cnt = sdfp_pkg::DMA_GAP_TICKS;
        end
      end
      sdfp_pkg::ST_WAIT: begin
        dq_drv  = cur.wr;
        lane_on = cur.wr;
        ma      = cur_col;
        mux_col = 1'b1;
        if (tick_r) begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) next_state = sdfp_pkg::ST_BST;
        end
      end
      sdfp_pkg::ST_BST: begin
        cmd = sdfp_pkg::CMD_BST;
        if (tick_r) begin
          next_state = sdfp_pkg::ST_INH;
          next_cnt   = inhs;
        end
      end
      sdfp_pkg::ST_INH: begin
        cmd = sdfp_pkg::CMD_INH;
        if (tick_r) begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_state = cur.dma ? sdfp_pkg::ST_GAP : sdfp_pkg::ST_IDLE;
            next_cnt   = sdfp_pkg::DMA_GAP_TICKS;
          end
        end
      end
      sdfp_pkg::ST_REF: begin
        cmd    = sdfp_pkg::CMD_REF;
        cas_fp = 1'b0;
        ras_fp = (beat == 3'h0);
        if (tick_r) begin
          next_beat = 3'h1;
          next_cnt  = cnt - 4'h1;
          if (!fp || cnt == 4'h1) begin
            next_state = cur.dma ? sdfp_pkg::ST_GAP : sdfp_pkg::ST_IDLE;
            next_cnt   = sdfp_pkg::DMA_GAP_TICKS;
          end
        end
      end
      sdfp_pkg::ST_GAP: begin
        if (tick_r) begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) next_state = sdfp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sdfp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state     <= sdfp_pkg::ST_IDLE;
      cnt       <= 4'h0;
      beat      <= 3'h0;
      cur       <= '0;
      row_open  <= 1'b0;
      open_row  <= 12'h000;
      init_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      beat  <= next_beat;
      if (pop) cur <= head;
      if (tick_r && state == sdfp_pkg::ST_LMR) init_done <= 1'b1;
      if (tick_r && state == sdfp_pkg::ST_PRE) row_open <= 1'b0;
      if (tick_r && state == sdfp_pkg::ST_ACT && !fp) begin
        row_open <= 1'b1;
        open_row <= cur_row;
      end
    end
  end

  // read capture after the configured latency
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cap_wait <= 4'h0;
      cap_left <= 3'h0;
      rdata    <= 32'h0;
    end else if (tick_r) begin
      if (state == sdfp_pkg::ST_RDWR && !cur.wr && !fp) begin
        cap_wait <= cl3 ? 4'h3 : 4'h2;
        cap_left <= last_beat + 3'h1;
      end else if (cap_wait != 4'h0) begin
        cap_wait <= cap_wait - 4'h1;
      end else if (cap_left != 3'h0) begin
        cap_left <= cap_left - 3'h1;
        rdata    <= dq_s2;
      end
      if (state == sdfp_pkg::ST_RDWR && !cur.wr && fp && cnt == 4'h0) rdata <= dq_s2;
    end
  end

  // pin registers: sdram strobes on the rise, fast-page ras/cas on the fall
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {MEM_CS_N_O, MEM_WE_N_O, MEM_RAS_N_O} <= 3'h7;
      MEM_CAS_N_O           <= 4'hF;
      BYTE_LANE_STROBE_N_O  <= 4'hF;
      MEM_ADDR_O            <= 12'h000;
      ROW_COL_ADDR_SELECT_O <= 1'b0;
      MEM_DQ_O              <= 32'h0;
      MEM_DQ_OE_O           <= 1'b0;
    end else begin
      if (tick_r) begin
        MEM_CS_N_O            <= cmd[3];
        MEM_WE_N_O            <= cmd[0];
        BYTE_LANE_STROBE_N_O  <= lane_on ? ~lanes : 4'hF;
        MEM_ADDR_O            <= ma;
        ROW_COL_ADDR_SELECT_O <= mux_col;
        MEM_DQ_O              <= cur.data;
        MEM_DQ_OE_O           <= dq_drv;
      end
      if (tick_r && !fp) begin
        MEM_RAS_N_O <= cmd[2];
        MEM_CAS_N_O <= {4{cmd[1]}};
      end else if (tick_f && fp) begin
        MEM_RAS_N_O <= ras_fp;
        MEM_CAS_N_O <= cas_fp ? 4'hF : (state == sdfp_pkg::ST_REF ? 4'h0 : ~lanes);
      end
    end
  end

  // helper counters for the spacing checks
  logic [3:0] nop_run, inh_run, gap_run;
  logic       in_inh, from_t1;
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {nop_run, inh_run, gap_run} <= 12'h000;
      in_inh <= 1'b0;
      from_t1 <= 1'b0;
    end else if (tick_r) begin
      nop_run <= (cmd == sdfp_pkg::CMD_RD) ? 4'h0 : nop_run + 4'(cmd == sdfp_pkg::CMD_NOP);
      inh_run <= (cmd == sdfp_pkg::CMD_BST) ? 4'h0 : inh_run + 4'(cmd == sdfp_pkg::CMD_INH);
      in_inh  <= (cmd == sdfp_pkg::CMD_BST) | (in_inh & (cmd == sdfp_pkg::CMD_INH));
      gap_run <= (state == sdfp_pkg::ST_GAP) ? gap_run + 4'h1 : 4'h0;
      from_t1 <= (state == sdfp_pkg::ST_T1);
    end
  end

  sequence s_bst_tick;
    tick_r && !fp && cl3 && !cur.wr && cmd == sdfp_pkg::CMD_BST;
  endsequence

  lane_select_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    BYTE_LANE_STROBE_N_O != 4'hF |-> BYTE_LANE_STROBE_N_O == ~lanes)
    else $error("byte strobes off the port width");
  fp_cas_lanes_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    fp && state == sdfp_pkg::ST_RDWR && tick_f |=> MEM_CAS_N_O == ~lanes)
    else $error("fast-page cas lanes wrong");
  row_hit_skip_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    pop && !fp && !head.refr && row_hit |=>
    state == sdfp_pkg::ST_T1 || state == sdfp_pkg::ST_RDWR)
    else $error("precharge or activate on row hit");
  single_nops_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    s_bst_tick and !cur.burst |-> nop_run == 4'h2)
    else $error("single read nop count");
  burst_nops_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    s_bst_tick and cur.burst |-> nop_run == 4'h5)
    else $error("burst read nop count");
  inhibit_run_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    tick_r && cl3 && !fp && in_inh && cmd != sdfp_pkg::CMD_INH |-> inh_run == 4'h3)
    else $error("inhibit count after terminate");
  write_col_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    tick_r && !fp && state == sdfp_pkg::ST_RDWR && cur.wr && from_t1
    |=> ROW_COL_ADDR_SELECT_O && MEM_ADDR_O == cur_col)
    else $error("write column address late");
  dma_gap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    tick_r && state == sdfp_pkg::ST_GAP && next_state == sdfp_pkg::ST_IDLE
    |-> gap_run == 4'hC)
    else $error("dma gap length");
  strobe_rise_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    $changed(BYTE_LANE_STROBE_N_O) || $changed(ROW_COL_ADDR_SELECT_O) |-> $past(tick_r))
    else $error("strobe moved off the rise");
  fp_fall_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    fp && $changed(MEM_RAS_N_O) |-> $past(tick_f))
    else $error("fast-page ras moved off the fall");
  load_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    tick_r && state == sdfp_pkg::ST_LMR |=> MEM_ADDR_O == mode && !MEM_CAS_N_O[0])
    else $error("load mode word wrong");
endmodule
`default_nettype wire

/* verilog/sdfp_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* tb/sdfp_mem_model.sv */
// Purpose: sdram partner, free bus clock and read data
// Assumes: commands are sampled on the bus clock rise
// Notes: outside a read the data bus shows the inverted word
`default_nettype none
module sdfp_mem_model #(
  parameter logic [31:0] RDW = 32'hA5C3_1E77
) (
  output logic            bclk_o,
  input  wire logic [3:0] cmd_i,
  input  wire logic       cl3_i,
  output logic     [31:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] left = 3'h0;
  initial bclk_o = 1'b0;
  always #80 bclk_o = ~bclk_o;
  // word held from latency through a four beat burst
  always @(posedge bclk_o) begin
    if (cmd_i === sdfp_pkg::CMD_RD)
      left <= cl3_i ? 3'h7 : 3'h6;
    else if (left != 3'h0)
      left <= left - 3'h1;
  end
  assign dq_o = (left != 3'h0 && left <= 3'h4) ? RDW : ~RDW;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench of the sequencer
// Assumes: bus clock comes from the memory model
// Notes: pins logged once a bus cycle, judged per scenario
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RDW = 32'hA5C3_1E77;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        fp = 1'b0, cl3 = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, dq_o, dq_i, rd;
  logic        pready, pslverr, bclk, cs, ras, we, sel, oe, err;
  logic [3:0]  cas, strb;
  logic [11:0] addr;
  logic [23:0] q[$];
  int          errors = 0, cmp_count = 0, wt;
  always #10 clk = ~clk;
  sdfp_seq i_sdfp_seq (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .BCLK_I(bclk), .MEM_CS_N_O(cs),
    .MEM_RAS_N_O(ras), .MEM_CAS_N_O(cas), .MEM_WE_N_O(we), .BYTE_LANE_STROBE_N_O(strb),
    .MEM_ADDR_O(addr), .ROW_COL_ADDR_SELECT_O(sel), .MEM_DQ_O(dq_o), .MEM_DQ_OE_O(oe),
    .MEM_DQ_I(dq_i));
  sdfp_mem_model #(.RDW(RDW)) i_sdfp_mem_model (.bclk_o(bclk), .cmd_i({cs, ras, cas[0], we}),
    .cl3_i(cl3), .dq_o(dq_i));
  // sdram pins settle by the fall, fast-page pins by the rise
  always @(bclk) if (bclk === fp) q.push_back({strb, sel, addr, cs, ras, cas, we});
  function automatic logic [3:0] cmd(input int i);
    return {q[i][6:5], q[i][1:0]};
  endfunction
  function automatic int find(input logic [3:0] c, input int from);
    for (int i = from; i < q.size(); i++) if (cmd(i) === c) return i;
    return -1;
  endfunction
  function automatic int run(input logic [3:0] c, input int from);
    int n;
    n = 0;
    while (from + n < q.size() && cmd(from + n) === c) n++;
    return n;
  endfunction
  // lanes seen low: cas in the upper half, strobes in the lower
  function automatic logic [7:0] low();
    logic [7:0] m;
    m = 8'h00;
    foreach (q[i]) m = m | ~{q[i][4:1], q[i][23:20]};
    return m;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    rd = prdata;
    err = pslverr;
    wt = n;
    if (n == 400) chk(n, 0);
    if (n == 400) end_sim();
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    int n;
    int k;
    n = 0;
    k = 0;
    // three idle polls in a row span more than one bus cycle
    do begin
      apb(1'b0, sdfp_pkg::OFS_STATUS, 32'h0);
      n++;
      k = (rd[1] === 1'b0 && rd[16] === 1'b0 && (fp || rd[0] === 1'b1)) ? k + 1 : 0;
    end while (k < 3 && n < 3000);
    if (n == 3000) chk(n, 0);
    if (n == 3000) end_sim();
  endtask
  task automatic req(input logic [31:0] r);
    q.delete();
    apb(1'b1, sdfp_pkg::OFS_REQUEST, r);
    wait_idle();
  endtask
  task automatic boot(input logic [31:0] cfg);
    int p;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    fp <= cfg[sdfp_pkg::CFG_FP];
    cl3 <= cfg[sdfp_pkg::CFG_CL3];
    @(posedge clk);
    q.delete();
    apb(1'b1, sdfp_pkg::OFS_CONFIG, cfg);
    wait_idle();
    p = find(sdfp_pkg::CMD_PRE, 0);
    if (!cfg[sdfp_pkg::CFG_FP]) chk(q[find(sdfp_pkg::CMD_LMR, p)][18:7], cfg[4] ?
      sdfp_pkg::MODE_CL3_BL1 : sdfp_pkg::MODE_CL2_BL1);
  endtask
  task automatic regs();
    apb(1'b0, sdfp_pkg::OFS_CONFIG, 32'h0);
    chk(rd, sdfp_pkg::CONFIG_RESET);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic rd_single(input logic [31:0] nops, input logic [31:0] inh, input logic [3:0] ln);
    int r;
    int b;
    req(32'h0000_1403);
    r = find(sdfp_pkg::CMD_RD, 0);
    b = find(sdfp_pkg::CMD_BST, r);
    chk(run(sdfp_pkg::CMD_NOP, r + 1), nops);
    chk(b - r - 1, nops);
    chk(run(sdfp_pkg::CMD_INH, b + 1), inh);
    chk(32'(low() & 8'h0F), 32'(ln));
    apb(1'b0, sdfp_pkg::OFS_RDATA, 32'h0);
    chk(rd, RDW);
  endtask
  task automatic hit();
    int w;
    req(32'h0200_1403);
    chk(find(sdfp_pkg::CMD_ACT, 0), -1);
    chk(run(sdfp_pkg::CMD_NOP, find(sdfp_pkg::CMD_RD, 0) + 1), 5);
    apb(1'b1, sdfp_pkg::OFS_WDATA, 32'h3C5A_96E1);
    req(32'h0100_1407);
    w = find(sdfp_pkg::CMD_WR, 0);
    chk(find(sdfp_pkg::CMD_ACT, 0), -1);
    chk(32'(q[w][19:7]), 32'h1007);
    chk(dq_o, 32'h3C5A_96E1);
    chk(32'(oe), 32'h0);
  endtask
  task automatic miss_dma();
    int a;
    int b;
    q.delete();
    apb(1'b1, sdfp_pkg::OFS_REQUEST, 32'h0400_1803);
    apb(1'b1, sdfp_pkg::OFS_REQUEST, 32'h0000_1803);
    wait_idle();
    a = find(sdfp_pkg::CMD_ACT, 0);
    chk(find(sdfp_pkg::CMD_PRE, 0) < a && a > 0, 1);
    chk(32'(q[a][19:7]), 32'h0006);
    b = find(sdfp_pkg::CMD_BST, a);
    b = b + 1 + run(sdfp_pkg::CMD_INH, b + 1);
    chk(run(sdfp_pkg::CMD_NOP, b) >= 13, 1);
  endtask
  task automatic fill();
    int m;
    m = 0;
    for (int i = 0; i < 40; i++) begin
      apb(1'b1, sdfp_pkg::OFS_REQUEST, 32'h0800_0000);
      if (wt > m) m = wt;
    end
    chk(m > 1, 1);
    wait_idle();
  endtask
  task automatic fp_mode();
    logic [3:0] ln[3];
    int n;
    ln = '{sdfp_pkg::LANES_8, sdfp_pkg::LANES_16, sdfp_pkg::LANES_32};
    for (int p = 0; p < 3; p++) begin
      boot(32'h23 | (p << 2) | ((p + 1) << 7));
      req(32'h0000_1403);
      chk(32'(low()), 32'({ln[p], ln[p]}));
      req(32'h0800_0000);
      chk(q.size() > 0 ? $countones(low() >> 4) > 0 : 0, 1);
      n = 0;
      foreach (q[i]) n += (q[i][4:1] === 4'h0);
      chk(n, p + 1);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    regs();
    boot(32'h0000_0019);
    rd_single(2, 3, sdfp_pkg::LANES_32);
    hit();
    miss_dma();
    fill();
    boot(32'h0000_0005);
    rd_single(1, 2, sdfp_pkg::LANES_16);
    fp_mode();
    end_sim();
  end
endmodule
`default_nettype wire
